// >>> fabc_defs.vh
// Constants for the flash bus controller: register offsets, fields, timing.
// Assumes a 100 MHz system clock; included by the controller and the bench.
`ifndef FABC_DEFS_VH
`define FABC_DEFS_VH
// Register byte offsets on the APB side
`define FABC_REG_CTRL 12'h000
`define FABC_REG_ADDR 12'h004
`define FABC_REG_WDATA 12'h008
`define FABC_REG_RDATA 12'h00C
`define FABC_REG_STAT 12'h010
`define FABC_REG_TIME 12'h014
// Control register fields
`define FABC_CTRL_GO 0
`define FABC_CTRL_WRITE 1
`define FABC_CTRL_WORD 2
`define FABC_CTRL_BOOST 3
`define FABC_CTRL_CLEAR 4
`define FABC_CTRL_PAGE 5
`define FABC_CTRL_RESET 32'h0000_0004
// Status register fields
`define FABC_STAT_BUSY 0
`define FABC_STAT_DONE 1
`define FABC_STAT_BOOST 2
// Timing in nanoseconds and clock period
`define FABC_CLK_NS 10
`define FABC_ACC_NS 90
`define FABC_PAGE_NS 25
`define FABC_CLEAR_NS 500
`define FABC_WR_PULSE_NS 35
// Cycle counts: least times round up
`define FABC_ACC_CYC ((`FABC_ACC_NS + `FABC_CLK_NS - 1) / `FABC_CLK_NS)
`define FABC_PAGE_CYC ((`FABC_PAGE_NS + `FABC_CLK_NS - 1) / `FABC_CLK_NS)
`define FABC_CLEAR_CYC ((`FABC_CLEAR_NS + `FABC_CLK_NS - 1) / `FABC_CLK_NS)
`define FABC_WR_CYC ((`FABC_WR_PULSE_NS + `FABC_CLK_NS - 1) / `FABC_CLK_NS)
// Write-buffer word limit per operation
`define FABC_WBUF_WORDS 16
`endif

// >>> fabc_sync.v
// Two-stage synchroniser for one level arriving from a pin.
// Assumes clk_sys domain; first stage feeds only the second.
`timescale 1ns/1ps
module fabc_sync
(
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Data
  input wire din,
  output reg dout
);
  reg meta; // First stage
  // Two flip-flops in series
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      meta <= 1'b0;
      dout <= 1'b0;
    end
    else
    begin
      meta <= din;
      dout <= meta;
    end
  end
endmodule // fabc_sync

// >>> fabc_timer.v
// Down-counter that pulses done when a loaded count expires.
// Assumes clk_sys domain; load has priority over counting.
`timescale 1ns/1ps
module fabc_timer
#(
  parameter W = 8
)
(
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // Control
  input wire load,
  input wire [W-1:0] count,
  // Status
  output reg done
);
  reg [W-1:0] cnt; // Remaining cycles
  reg run; // Counting
  // Count down and pulse at zero
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      cnt <= {W{1'b0}};
      run <= 1'b0;
      done <= 1'b0;
    end
    else if (load)
    begin
      cnt <= count;
      run <= 1'b1;
      done <= 1'b0;
    end
    else if (run && cnt <= {{(W-1){1'b0}}, 1'b1})
    begin
      run <= 1'b0;
      done <= 1'b1;
    end
    else
    begin
      cnt <= run ? cnt - {{(W-1){1'b0}}, 1'b1} : cnt;
      done <= 1'b0;
    end
  end
endmodule // fabc_timer

// >>> fabc_ctrl.v
// Host-side controller for an asynchronous parallel NOR flash bus.
// Assumes software on APB; flash pins are asynchronous to clk_sys.
// Software issues the command sequences; this block moves single bus cycles.
// Notes on behaviour
// - Read: address valid, select, enable low
// - Write: strobe and select low, enable high
// - Short mode programs in two cycles
// - Buffer load at most sixteen words
// - Boost voltage only while programming
// - Reissue program cut short by reset
//
// The address map and register access over APB were decided locally.
`timescale 1ns/1ps
`include "fabc_defs.vh"
module fabc_ctrl
#(
  parameter AW = 22
)
(
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB slave
  input wire psel,
  input wire penable,
  input wire pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  output reg [31:0] prdata,
  output reg pready,
  output reg pslverr,
  // Flash control pins
  output reg chip_sel_n,
  output reg out_en_n,
  output reg wr_strobe_n,
  output reg clear_n,
  output reg width_word,
  output reg fast_program_pin,
  output reg [AW-1:0] flash_addr,
  // Flash data pins, split
  input wire [15:0] dq_in,
  output reg [15:0] dq_out,
  output reg [15:0] dq_oe
);
  localparam ST_IDLE = 5'b00001; // Bus parked
  localparam ST_RD = 5'b00010; // Read access wait
  localparam ST_WR = 5'b00100; // Write strobe low
  localparam ST_GAP = 5'b01000; // Recovery between cycles
  localparam ST_CLR = 5'b10000; // Device clear pulse
  // Timing counts in cycles; the timer is eight bits wide
  localparam integer ACC_I = `FABC_ACC_CYC; // Full access at reset
  localparam integer PAGE_I = `FABC_PAGE_CYC; // Access inside an open page
  localparam integer CLEAR_I = `FABC_CLEAR_CYC; // Device clear pulse
  localparam integer WR_I = `FABC_WR_CYC; // Write strobe low time
  localparam [7:0] SYNC_CYC = 8'h02; // Synchroniser stages on the data pins
  reg [4:0] state; // Bus sequencer state
  reg [31:0] ctrl; // Control register
  reg [AW-1:0] addr_reg; // Target address
  reg [15:0] wdata_reg; // Write data
  reg [15:0] rdata_reg; // Last read data
  reg done; // Sticky completion flag
  reg page_open; // Page open with select held
  reg [AW-4:0] page_tag; // Open page address bits
  reg [7:0] acc_cyc; // Programmable full access count
  reg [7:0] wbuf_cnt; // Words written in current buffer load
  wire [15:0] dq_sync; // Synchronised data pins
  reg tmr_load; // Timer start
  reg [7:0] tmr_count; // Timer value
  wire tmr_done; // Timer expiry
  wire apb_wr = psel && penable && pwrite && pready; // Write completes
  wire go_pulse = apb_wr && paddr == `FABC_REG_CTRL && pwdata[`FABC_CTRL_GO];
  // Word address on the pins; byte mode moves bit 0 onto DQ15
  wire [AW-1:0] word_addr = width_word ? addr_reg : {1'b0, addr_reg[AW-1:1]};
  // Page hit: same page while select is still held
  wire same_page = page_open && page_tag == word_addr[AW-1:3];
  // Data pins pass two flip-flops each
  genvar gi;
  generate
    for (gi = 0; gi < 16; gi = gi + 1)
    begin : g_sync
      fabc_sync u_sync
      (
        .clk_sys(clk_sys),
        .reset_n(reset_n),
        .din(dq_in[gi]),
        .dout(dq_sync[gi])
      );
    end
  endgenerate
  // Access timer shared by every phase
  fabc_timer #(.W(8)) u_timer
  (
    .clk_sys(clk_sys),
    .reset_n(reset_n),
    .load(tmr_load),
    .count(tmr_count),
    .done(tmr_done)
  );
  // APB answers with no wait state; unmapped reads give zero
  // Status is sampled in the setup cycle and returned in the access cycle
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      prdata <= 32'h0000_0000;
      pready <= 1'b0;
      pslverr <= 1'b0;
    end
    else
    begin
      pready <= psel && !penable;
      pslverr <= 1'b0;
      if (psel && !penable && !pwrite)
      begin
        case (paddr)
          `FABC_REG_CTRL: prdata <= ctrl;
          `FABC_REG_ADDR: prdata <= {{(32-AW){1'b0}}, addr_reg};
          `FABC_REG_WDATA: prdata <= {16'h0000, wdata_reg};
          `FABC_REG_RDATA: prdata <= {16'h0000, rdata_reg};
          `FABC_REG_STAT: prdata <= {21'h0, wbuf_cnt, fast_program_pin, done,
            state != ST_IDLE};
          `FABC_REG_TIME: prdata <= {24'h000000, acc_cyc};
          default: prdata <= 32'h0000_0000;
        endcase
      end
    end
  end
  // Register writes and the bus sequencer
  always @(posedge clk_sys or negedge reset_n)
  begin
    if (!reset_n)
    begin
      ctrl <= `FABC_CTRL_RESET;
      addr_reg <= {AW{1'b0}};
      wdata_reg <= 16'h0000;
      rdata_reg <= 16'h0000;
      acc_cyc <= ACC_I[7:0];
      done <= 1'b0;
      state <= ST_IDLE;
      page_open <= 1'b0;
      page_tag <= {(AW-3){1'b0}};
      wbuf_cnt <= 8'h00;
      tmr_load <= 1'b0;
      tmr_count <= 8'h00;
      chip_sel_n <= 1'b1;
      out_en_n <= 1'b1;
      wr_strobe_n <= 1'b1;
      clear_n <= 1'b0;
      width_word <= 1'b1;
      fast_program_pin <= 1'b0;
      flash_addr <= {AW{1'b0}};
      dq_out <= 16'h0000;
      dq_oe <= 16'h0000;
    end
    else
    begin
      tmr_load <= 1'b0;
      // Software writes; busy blocks changes to target fields
      if (apb_wr && state == ST_IDLE)
      begin
        case (paddr)
          `FABC_REG_CTRL: ctrl <= {26'h0, pwdata[5:1], 1'b0};
          `FABC_REG_ADDR: addr_reg <= pwdata[AW-1:0];
          `FABC_REG_WDATA: wdata_reg <= pwdata[15:0];
          `FABC_REG_TIME: acc_cyc <= pwdata[7:0];
          default: ;
        endcase
      end
      // A start pulse from idle clears done
      if (go_pulse && state == ST_IDLE)
        done <= 1'b0;
      // Idle parks the bus; a read waits the access time plus the two
      // synchroniser stages; a write holds the strobe for the pulse time,
      // then a short gap keeps data past the strobe rise; clear holds the
      // device reset for its pulse width
      case (state)
        ST_IDLE:
        begin
          clear_n <= 1'b1; // Device leaves reset into array read
          // Width follows the register only with select released
          if (chip_sel_n)
            width_word <= ctrl[`FABC_CTRL_WORD];
          // Boost stays off outside a boosted write
          fast_program_pin <= 1'b0;
          if (go_pulse)
          begin
            if (pwdata[`FABC_CTRL_CLEAR])
            begin
              // Pulse clear; boost dropped, select released
              chip_sel_n <= 1'b1;
              page_open <= 1'b0;
              fast_program_pin <= 1'b0;
              clear_n <= 1'b0;
              tmr_count <= CLEAR_I[7:0];
              tmr_load <= 1'b1;
              wbuf_cnt <= 8'h00;
              state <= ST_CLR;
            end
            else if (pwdata[`FABC_CTRL_WRITE])
            begin
              // Strobe and select low, enable high
              // One cycle of a software sequence; short mode needs two
              flash_addr <= word_addr;
              chip_sel_n <= 1'b0;
              out_en_n <= 1'b1;
              wr_strobe_n <= 1'b0;
              dq_out <= width_word ? wdata_reg :
                {addr_reg[0], 7'h00, wdata_reg[7:0]}; // DQ15 carries byte addr
              dq_oe <= width_word ? 16'hFFFF : 16'h80FF;
              // Boost voltage only for this programming cycle
              fast_program_pin <= pwdata[`FABC_CTRL_BOOST];
              page_open <= 1'b0;
              // Count words of a buffer load up to its limit
              wbuf_cnt <= (wbuf_cnt == `FABC_WBUF_WORDS) ? 8'h01 : wbuf_cnt + 8'h01;
              tmr_count <= WR_I[7:0];
              tmr_load <= 1'b1;
              state <= ST_WR;
            end
            else
            begin
              // Read: select and enable low, strobe high
              flash_addr <= word_addr;
              chip_sel_n <= 1'b0;
              out_en_n <= 1'b0;
              wr_strobe_n <= 1'b1;
              dq_out <= width_word ? 16'h0000 : {addr_reg[0], 15'h0000};
              dq_oe <= width_word ? 16'h0000 : 16'h8000;
              // Open page with select held needs only page time
              tmr_count <= (pwdata[`FABC_CTRL_PAGE] && same_page) ?
                PAGE_I[7:0] + SYNC_CYC : acc_cyc + SYNC_CYC; // Plus sync delay
              tmr_load <= 1'b1;
              state <= ST_RD;
            end
          end
        end
        ST_RD:
        begin
          if (tmr_done)
          begin
            // Data pins have settled through both synchroniser stages
            // Byte mode and query codes use the low lane
            rdata_reg <= width_word ? dq_sync : {8'h00, dq_sync[7:0]};
            out_en_n <= 1'b1; // Device floats with enable high
            dq_oe <= 16'h0000;
            done <= 1'b1;
            page_tag <= word_addr[AW-1:3];
            // Keep select for page mode, else standby
            page_open <= ctrl[`FABC_CTRL_PAGE];
            chip_sel_n <= !ctrl[`FABC_CTRL_PAGE];
            state <= ST_IDLE;
          end
        end
        ST_WR:
        begin
          if (tmr_done)
          begin
            wr_strobe_n <= 1'b1;
            chip_sel_n <= 1'b1; // Device carries on alone
            // Data stays driven through the gap for hold time
            tmr_count <= 8'h02;
            tmr_load <= 1'b1;
            state <= ST_GAP;
          end
        end
        ST_GAP:
        begin
          if (tmr_done)
          begin
            dq_oe <= 16'h0000;
            fast_program_pin <= 1'b0; // Boost removed after the write
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        ST_CLR:
        begin
          if (tmr_done)
          begin
            clear_n <= 1'b1; // Software should reissue aborted program
            done <= 1'b1;
            state <= ST_IDLE;
          end
        end
        default: state <= ST_IDLE;
      endcase
    end
  end
endmodule // fabc_ctrl

// >>> fabc_flash_model.sv
// Behavioural model of the flash device on the controller's pins.
// Assumes the pin set of fabc_ctrl; it resolves the split data wire.
`timescale 1ns/1ps
module fabc_flash_model
#(
  parameter ACC_NS = 90,
  parameter PAGE_NS = 25
)
(
  // Control pins
  input wire chip_sel_n,
  input wire out_en_n,
  input wire wr_strobe_n,
  input wire clear_n,
  input wire width_word,
  input wire [21:0] flash_addr,
  // Data wire halves
  input wire [15:0] dq_out,
  input wire [15:0] dq_oe,
  output reg [15:0] dq_in
);
  reg [15:0] mem [0:255]; // Array words
  reg [15:0] last = 16'h0000; // Last value driven
  reg [15:0] rd; // Value the device would drive
  reg [18:0] pg = 19'h00000; // Page of the last address
  reg cs_d = 1'b1; // Select seen before
  reg first = 1'b1; // No access done since select fell
  reg ok; // Data valid on the wire
  realtime t_chg = 0; // Last change of address, select or enable
  realtime need = ACC_NS; // Access time now due
  integer i;
  // Array contents readable from time zero
  initial for (i = 0; i < 256; i = i + 1) mem[i] = {i[7:0], 8'hC3};
  // Full access after select falls or page changes, else page time
  always @(flash_addr or out_en_n or chip_sel_n)
  begin
    if (cs_d && !chip_sel_n)
      first = 1'b1;
    cs_d = chip_sel_n;
    need = (first || flash_addr[21:3] != pg) ? ACC_NS : PAGE_NS;
    pg = flash_addr[21:3];
    t_chg = $realtime;
  end
  // Drive data, drive the inverted last value, or store every nanosecond
  always #1
  begin
    ok = !chip_sel_n && !out_en_n && wr_strobe_n && clear_n
      && ($realtime - t_chg >= need);
    if (ok)
      first = 1'b0;
    rd = width_word ? mem[flash_addr[7:0]] : {~last[15:8], dq_out[15] ?
      mem[flash_addr[7:0]][15:8] : mem[flash_addr[7:0]][7:0]};
    if (!chip_sel_n && !wr_strobe_n && out_en_n && clear_n && width_word)
      mem[flash_addr[7:0]] = dq_out;
    for (i = 0; i < 16; i = i + 1)
      dq_in[i] = dq_oe[i] ? dq_out[i] : (ok ? rd[i] : ~last[i]);
    if (ok)
      last = rd;
  end
endmodule // fabc_flash_model

// >>> fabc_ctrl_assertions.sv
// Checker on the pins of fabc_ctrl.
// Assumes one clock domain; bound into every controller instance.
`timescale 1ns/1ps
module fabc_ctrl_assertions
(
  // Clock and reset
  input wire clk_sys,
  input wire reset_n,
  // APB
  input wire psel,
  input wire penable,
  input wire pready,
  input wire pslverr,
  // Flash pins
  input wire chip_sel_n,
  input wire out_en_n,
  input wire wr_strobe_n,
  input wire width_word,
  input wire fast_program_pin,
  input wire [15:0] dq_oe
);
  default clocking cb @(posedge clk_sys); endclocking
  default disable iff (!reset_n);
  // Write strobe held low six cycles, then released
  sequence s_we_low;
    !wr_strobe_n [*6];
  endsequence
  sequence s_we_end;
    wr_strobe_n;
  endsequence
  a_read_we_high: assert property (!chip_sel_n && !out_en_n |-> wr_strobe_n)
    else $error("write strobe low in read");
  a_write_oe_high: assert property (!wr_strobe_n |-> !chip_sel_n && out_en_n)
    else $error("write without select or with enable");
  a_drive_oe_high: assert property ((dq_oe & 16'h7FFF) != 16'h0000 |-> out_en_n)
    else $error("data driven while flash enabled");
  a_we_pulse_len: assert property ($fell(wr_strobe_n) |-> s_we_low ##1 s_we_end)
    else $error("write pulse length wrong");
  a_boost_no_read: assert property (fast_program_pin |-> out_en_n)
    else $error("boost during read");
  a_width_idle: assert property ($changed(width_word) |-> chip_sel_n)
    else $error("width changed while selected");
  a_apb_answer: assert property (psel && !penable |=> pready)
    else $error("no ready in access cycle");
  a_ready_single: assert property (pready |=> !pready)
    else $error("ready longer than one cycle");
  a_no_slverr: assert property (pready |-> !pslverr)
    else $error("error response");
  c_boost: cover property (fast_program_pin);
endmodule // fabc_ctrl_assertions
bind fabc_ctrl fabc_ctrl_assertions u_chk (.clk_sys(clk_sys), .reset_n(reset_n),
  .psel(psel), .penable(penable), .pready(pready), .pslverr(pslverr),
  .chip_sel_n(chip_sel_n), .out_en_n(out_en_n), .wr_strobe_n(wr_strobe_n),
  .width_word(width_word), .fast_program_pin(fast_program_pin), .dq_oe(dq_oe));

// >>> tb.sv
// Self-checking bench: APB software side, flash model on the pins.
// Assumes word mode uses the address register as the flash word address.
`timescale 1ns/1ps
`include "fabc_defs.vh"
`define CHK(a, b) begin num_checks = num_checks + 1; if ((a) !== (b)) begin \
  err_count = err_count + 1; $display("wrong value %0t %h %h", $time, (a), (b)); end end
module tb;
  reg clk_sys = 1'b0;
  reg reset_n = 1'b0;
  reg psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
  reg [11:0] paddr = 12'h000;
  reg [31:0] pwdata = 32'h0, q;
  wire [31:0] prdata;
  wire pready, pslverr, chip_sel_n, out_en_n, wr_strobe_n, clear_n, width_word, fast_program_pin;
  wire [21:0] flash_addr;
  wire [15:0] dq_in, dq_out, dq_oe;
  integer err_count = 0, num_checks = 0;
  fabc_ctrl u_dut (.clk_sys(clk_sys), .reset_n(reset_n), .psel(psel), .penable(penable),
    .pwrite(pwrite), .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready),
    .pslverr(pslverr), .chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n), .clear_n(clear_n), .width_word(width_word),
    .fast_program_pin(fast_program_pin), .flash_addr(flash_addr), .dq_in(dq_in),
    .dq_out(dq_out), .dq_oe(dq_oe));
  fabc_flash_model u_mem (.chip_sel_n(chip_sel_n), .out_en_n(out_en_n),
    .wr_strobe_n(wr_strobe_n), .clear_n(clear_n), .width_word(width_word),
    .flash_addr(flash_addr), .dq_out(dq_out), .dq_oe(dq_oe), .dq_in(dq_in));
  // Free-running system clock
  initial forever #5 clk_sys = ~clk_sys;
  // Verdict and end of run
  task complete_run;
    if (err_count == 0 && num_checks > 0)
      $display("[ PASS ]");
    else
      $display("[ FAIL ]");
    $finish;
  endtask
  // One APB transfer; read data lands in q
  task apb(input w, input [11:0] a, input [31:0] d);
    @(posedge clk_sys);
    psel <= 1'b1;
    pwrite <= w;
    paddr <= a;
    pwdata <= d;
    @(posedge clk_sys);
    penable <= 1'b1;
    do @(posedge clk_sys); while (pready !== 1'b1);
    q = prdata;
    psel <= 1'b0;
    penable <= 1'b0;
  endtask
  // Poll status until done
  task wait_done;
    integer n;
    n = 0;
    q = 32'h0;
    while (q[`FABC_STAT_DONE] !== 1'b1 && n < 300)
    begin
      apb(1'b0, `FABC_REG_STAT, 32'h0);
      n = n + 1;
    end
    `CHK(q[`FABC_STAT_DONE], 1'b1)
  endtask
  // Address, then mode alone so the width settles, then the start pulse
  task go(input [31:0] a, input [31:0] f);
    apb(1'b1, `FABC_REG_ADDR, a);
    apb(1'b1, `FABC_REG_CTRL, f);
    apb(1'b1, `FABC_REG_CTRL, f | 32'h1);
  endtask
  // Flash operation at an address, read data register after
  task op(input [31:0] a, input [31:0] f);
    go(a, f);
    wait_done;
    apb(1'b0, `FABC_REG_RDATA, 32'h0);
  endtask
  // Reset values and an unmapped place
  task t_reset;
    apb(1'b0, `FABC_REG_CTRL, 32'h0);
    `CHK(q, `FABC_CTRL_RESET)
    apb(1'b0, `FABC_REG_TIME, 32'h0);
    `CHK(q, 32'h9)
    apb(1'b0, 12'h020, 32'h0);
    `CHK(q, 32'h0)
    `CHK(clear_n, 1'b1)
  endtask
  // Word write, refused write while busy, read back
  task t_word;
    apb(1'b1, `FABC_REG_ADDR, 32'h12);
    apb(1'b1, `FABC_REG_WDATA, 32'hA55A);
    apb(1'b1, `FABC_REG_CTRL, 32'h7);
    apb(1'b1, `FABC_REG_ADDR, 32'h77);
    wait_done;
    apb(1'b0, `FABC_REG_ADDR, 32'h0);
    `CHK(q, 32'h12)
    op(32'h12, 32'h4);
    `CHK(q[15:0], 16'hA55A)
  endtask
  // Page hits keep select low; a read without page mode releases it
  task t_page;
    op(32'h30, 32'h24);
    `CHK(q[15:0], 16'h30C3)
    `CHK(chip_sel_n, 1'b0)
    op(32'h31, 32'h24);
    `CHK(q[15:0], 16'h31C3)
    op(32'h38, 32'h4);
    `CHK(q[15:0], 16'h38C3)
    `CHK(chip_sel_n, 1'b1)
  endtask
  // Byte read, two-cycle boosted write, clear pulse
  task t_modes;
    op(32'h81, 32'h0);
    `CHK(q[15:0], 16'h0040)
    `CHK(width_word, 1'b0)
    apb(1'b1, `FABC_REG_WDATA, 32'h0011);
    go(32'h55, 32'hE);
    wait_done;
    apb(1'b1, `FABC_REG_WDATA, 32'h1234);
    go(32'h40, 32'hE);
    apb(1'b0, `FABC_REG_STAT, 32'h0);
    `CHK(q[`FABC_STAT_BOOST], 1'b1)
    wait_done;
    `CHK(fast_program_pin, 1'b0)
    apb(1'b0, `FABC_REG_STAT, 32'h0);
    `CHK(q[10:3], 8'h03)
    go(32'h0, 32'h14);
    apb(1'b0, `FABC_REG_STAT, 32'h0);
    `CHK(clear_n, 1'b0)
    `CHK(q[`FABC_STAT_BUSY], 1'b1)
    wait_done;
    `CHK(clear_n, 1'b1)
    op(32'h40, 32'h4);
    `CHK(q[15:0], 16'h1234)
  endtask
  // Main sequence
  initial
  begin
    repeat (6) @(posedge clk_sys);
    reset_n <= 1'b1;
    t_reset;
    t_word;
    t_page;
    t_modes;
    complete_run;
  end
  // Watchdog
  initial
  begin
    #300000;
    err_count = err_count + 1;
    complete_run;
  end
endmodule // tb
